// File: mbc_pkg.sv
package mbc_pkg;
    // ------------------------------------------------------------
    // clock and times
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned PRESS_MIN_MS    = 150;
    localparam int unsigned PRESS_MAX_MS    = 4000;
    localparam int unsigned INVERT_MAX_MS   = 500;
    localparam int unsigned DROPOUT_MS      = 300;
    localparam int unsigned SINGLE_MAX_MS   = 4000;
    localparam int unsigned MUTE_MAX_MIN    = 10;
    localparam int unsigned PRESS_MIN_CYC   = PRESS_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned PRESS_MAX_CYC   = PRESS_MAX_MS * (CLK_HZ / 1000);
    localparam int unsigned INVERT_MAX_CYC  = INVERT_MAX_MS * (CLK_HZ / 1000);
    localparam int unsigned DROPOUT_CYC     = DROPOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned SINGLE_MAX_CYC  = SINGLE_MAX_MS * (CLK_HZ / 1000);
    localparam longint unsigned MUTE_MAX_CYC =
        longint'(MUTE_MAX_MIN) * 60 * CLK_HZ;
    // ------------------------------------------------------------
    // modes and sizes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_ONE   = 3'h1;
    localparam logic [2:0] MODE_THREE = 3'h3;
    localparam logic [2:0] MODE_FOUR  = 3'h4;
    localparam logic [2:0] MODE_SIX   = 3'h6;
    localparam int unsigned NUM_AREAS = 10;
    localparam int unsigned CNT_W     = 32;
    localparam logic [7:0] TEACH_SIZE_ERROR_MSG = 8'h47;
    localparam logic [7:0] MSG_NONE             = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;
    // ------------------------------------------------------------
    // teach states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        T_IDLE   = 3'b001,
        T_ACTIVE = 3'b010,
        T_FAIL   = 3'b100
    } teach_state_t;
    // ------------------------------------------------------------
    // mute states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        M_NORMAL  = 4'b0001,
        M_MUTING  = 4'b0010,
        M_RESTART = 4'b0100,
        M_LOCKED  = 4'b1000
    } mute_state_t;
endpackage

// File: muting_blanking_control.sv
`timescale 1ns/10ps
module muting_blanking_control
    import mbc_pkg::*;
#(
    parameter int unsigned BEAMS      = 32,
    parameter int unsigned PRESS_MIN  = PRESS_MIN_CYC,
    parameter int unsigned PRESS_MAX  = PRESS_MAX_CYC,
    parameter int unsigned INVERT_MAX = INVERT_MAX_CYC,
    parameter int unsigned DROPOUT    = DROPOUT_CYC,
    parameter int unsigned SINGLE_MAX = SINGLE_MAX_CYC,
    parameter longint unsigned MUTE_MAX = MUTE_MAX_CYC,
    parameter int unsigned FLASH_HALF = 2_500_000
) (
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic [2:0]       mode_in,
    input  wire logic             function_group_one_in,
    input  wire logic [BEAMS-1:0] beam_blocked_in,
    input  wire logic             ctrl_a_in,
    input  wire logic             ctrl_b_in,
    input  wire logic             teach_key_in,
    input  wire logic             reset_button_in,
    input  wire logic             mute_sensor_a_in,
    input  wire logic             mute_sensor_b_in,
    input  wire logic             error_in,
    output logic                  safety_switch_output_out,
    output logic                  blanking_indicator_out,
    output logic                  muting_active_out,
    output logic                  reduced_resolution_out,
    output logic                  floating_blanking_out,
    output logic                  restart_required_out,
    output logic [7:0]            user_msg_out,
    output logic [3:0]            area_count_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
        return (c == 32'hFFFF_FFFF) ? c : c + CNT_ONE;
    endfunction
    function automatic logic press_ok(input logic [CNT_W-1:0] c,
                                      input int unsigned lo,
                                      input int unsigned hi);
        return (c >= CNT_W'(lo)) && (c <= CNT_W'(hi));
    endfunction

    // ------------------------------------------------------------
    // key press timing
    // ------------------------------------------------------------
    logic             teach_key_r;
    logic             reset_btn_r;
    logic [CNT_W-1:0] teach_cnt_r;
    logic [CNT_W-1:0] reset_cnt_r;
    logic             teach_press_ok;
    logic             reset_press_ok;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            teach_key_r <= 1'b0;
            reset_btn_r <= 1'b0;
            teach_cnt_r <= CNT_ZERO;
            reset_cnt_r <= CNT_ZERO;
        end else begin
            teach_key_r <= teach_key_in;
            reset_btn_r <= reset_button_in;
            teach_cnt_r <= teach_key_in ? sat_inc(teach_cnt_r) : CNT_ZERO;
            reset_cnt_r <= reset_button_in ? sat_inc(reset_cnt_r) : CNT_ZERO;
        end
    end

    assign teach_press_ok = teach_key_r && !teach_key_in &&
        press_ok(teach_cnt_r, PRESS_MIN, PRESS_MAX);
    assign reset_press_ok = reset_btn_r && !reset_button_in &&
        press_ok(reset_cnt_r, PRESS_MIN, PRESS_MAX);

    // ------------------------------------------------------------
    // antivalent blanking control
    // ------------------------------------------------------------
    logic             ctrl_a_r;
    logic             ctrl_b_r;
    logic [CNT_W-1:0] inv_cnt_r;
    logic             inv_wait_r;
    logic             blank_en_r;
    logic             ctrl_mode;
    logic             a_flip;
    logic             b_flip;

    assign ctrl_mode = (mode_in == MODE_ONE) || (mode_in == MODE_THREE);
    assign a_flip    = ctrl_a_in != ctrl_a_r;
    assign b_flip    = ctrl_b_in != ctrl_b_r;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_a_r   <= 1'b0;
            ctrl_b_r   <= 1'b1;
            inv_cnt_r  <= CNT_ZERO;
            inv_wait_r <= 1'b0;
            blank_en_r <= 1'b0;
        end else begin
            ctrl_a_r <= ctrl_a_in;
            ctrl_b_r <= ctrl_b_in;
            if (!ctrl_mode) begin
                inv_wait_r <= 1'b0;
                blank_en_r <= 1'b0;
            end else if (a_flip && b_flip && (ctrl_a_in != ctrl_b_in)) begin
                blank_en_r <= ctrl_a_in;
                inv_wait_r <= 1'b0;
            end else if (!inv_wait_r && (a_flip ^ b_flip)) begin
                inv_wait_r <= 1'b1;
                inv_cnt_r  <= CNT_ZERO;
            end else if (inv_wait_r) begin
                inv_cnt_r <= sat_inc(inv_cnt_r);
                if (ctrl_a_in != ctrl_b_in) begin
                    inv_wait_r <= 1'b0;
                    if (inv_cnt_r < CNT_W'(INVERT_MAX)) begin
                        blank_en_r <= ctrl_a_in;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // teach of floating blanking areas
    // ------------------------------------------------------------
    teach_state_t     teach_st_r;
    logic [BEAMS-1:0] taught_mask_r;
    logic [BEAMS-1:0] move_range_r;
    logic [7:0]       obj_size_r;
    logic [7:0]       cur_size;
    logic             size_seen_r;
    logic [CNT_W-1:0] flash_cnt_r;
    logic             flash_r;
    logic [7:0]       area_size_r [NUM_AREAS];
    logic [3:0]       areas;

    always_comb begin
        cur_size = 8'h00;
        for (int i = 0; i < BEAMS; i++) begin
            cur_size = cur_size + 8'(beam_blocked_in[i]);
        end
        areas = 4'h0;
        for (int i = 0; i < BEAMS; i++) begin
            if (move_range_r[i] && (i == 0 || !move_range_r[i-1]) &&
                areas < 4'(NUM_AREAS)) begin
                areas = areas + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            teach_st_r    <= T_IDLE;
            taught_mask_r <= '0;
            move_range_r  <= '0;
            obj_size_r    <= 8'h00;
            size_seen_r   <= 1'b0;
            user_msg_out  <= MSG_NONE;
            area_count_out <= 4'h0;
            for (int i = 0; i < NUM_AREAS; i++) area_size_r[i] <= 8'h00;
        end else begin
            unique case (teach_st_r)
                T_IDLE, T_FAIL: begin
                    if (teach_press_ok) begin
                        teach_st_r   <= T_ACTIVE;
                        move_range_r <= '0;
                        size_seen_r  <= 1'b0;
                        user_msg_out <= MSG_NONE;
                    end
                end
                T_ACTIVE: begin
                    move_range_r <= move_range_r | beam_blocked_in;
                    if (cur_size != 8'h00) begin
                        size_seen_r <= 1'b1;
                        obj_size_r  <= cur_size;
                    end
                    if (size_seen_r && cur_size != 8'h00 &&
                        (cur_size > obj_size_r + 8'h01 ||
                         obj_size_r > cur_size + 8'h01)) begin
                        teach_st_r   <= T_FAIL;
                        user_msg_out <= TEACH_SIZE_ERROR_MSG;
                    end else if (teach_press_ok) begin
                        teach_st_r     <= T_IDLE;
                        taught_mask_r  <= move_range_r;
                        area_count_out <= areas;
                        for (int i = 0; i < NUM_AREAS; i++) begin
                            area_size_r[i] <= (4'(i) < areas) ?
                                obj_size_r : 8'h00;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flash_cnt_r <= CNT_ZERO;
            flash_r     <= 1'b0;
        end else if (teach_st_r != T_ACTIVE) begin
            flash_cnt_r <= CNT_ZERO;
            flash_r     <= 1'b0;
        end else if (flash_cnt_r >= CNT_W'(FLASH_HALF - 1)) begin
            flash_cnt_r <= CNT_ZERO;
            flash_r     <= !flash_r;
        end else begin
            flash_cnt_r <= flash_cnt_r + CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // blanking outputs
    // ------------------------------------------------------------
    logic float_on;
    logic red_res;
    logic blank_active;

    assign float_on = (mode_in == MODE_THREE) && blank_en_r;
    assign red_res  = float_on && function_group_one_in;
    assign blank_active = blank_en_r && (taught_mask_r != '0);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            blanking_indicator_out <= 1'b0;
            floating_blanking_out  <= 1'b0;
            reduced_resolution_out <= 1'b0;
        end else begin
            blanking_indicator_out <= (teach_st_r == T_ACTIVE) ? flash_r :
                blank_active;
            floating_blanking_out  <= red_res;
            reduced_resolution_out <= red_res;
        end
    end

    // ------------------------------------------------------------
    // field evaluation
    // ------------------------------------------------------------
    logic [BEAMS-1:0] eff_blocked;
    logic             field_broken;
    logic             end_beam_broken;

    // objects of any size in the taught range are not counted while blanking is on
    assign eff_blocked  = (blank_active || red_res) ?
        (beam_blocked_in & ~taught_mask_r) : beam_blocked_in;
    assign field_broken = eff_blocked != '0;
    assign end_beam_broken = (mode_in == MODE_SIX) &&
        beam_blocked_in[BEAMS-1];

    // ------------------------------------------------------------
    // timing-controlled muting
    // ------------------------------------------------------------
    mute_state_t      mute_st_r;
    logic [CNT_W-1:0] both_off_r;
    logic [CNT_W-1:0] a_off_r;
    logic [CNT_W-1:0] b_off_r;
    logic [39:0]      mute_time_r;
    logic             mute_mode;
    logic             both_on;
    logic             mute_end;

    assign mute_mode = (mode_in == MODE_FOUR) || (mode_in == MODE_SIX);
    assign both_on   = mute_sensor_a_in && mute_sensor_b_in;
    assign mute_end  =
        (both_off_r >= CNT_W'(DROPOUT)) ||
        (a_off_r >= CNT_W'(SINGLE_MAX)) ||
        (b_off_r >= CNT_W'(SINGLE_MAX)) ||
        (mute_time_r >= 40'(MUTE_MAX)) || !mute_mode;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            both_off_r  <= CNT_ZERO;
            a_off_r     <= CNT_ZERO;
            b_off_r     <= CNT_ZERO;
            mute_time_r <= 40'h00_0000_0000;
        end else if (mute_st_r != M_MUTING) begin
            both_off_r  <= CNT_ZERO;
            a_off_r     <= CNT_ZERO;
            b_off_r     <= CNT_ZERO;
            mute_time_r <= 40'h00_0000_0000;
        end else begin
            both_off_r <= (!mute_sensor_a_in && !mute_sensor_b_in) ?
                sat_inc(both_off_r) : CNT_ZERO;
            a_off_r     <= mute_sensor_a_in ? CNT_ZERO : sat_inc(a_off_r);
            b_off_r     <= mute_sensor_b_in ? CNT_ZERO : sat_inc(b_off_r);
            mute_time_r <= mute_time_r + 40'h00_0000_0001;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mute_st_r <= M_LOCKED;
        end else begin
            unique case (mute_st_r)
                M_NORMAL: begin
                    if (field_broken && mute_mode && both_on) begin
                        mute_st_r <= M_RESTART;
                    end else if (field_broken) begin
                        mute_st_r <= M_LOCKED;
                    end else if (mute_mode && both_on) begin
                        mute_st_r <= M_MUTING;
                    end
                end
                M_MUTING: begin
                    if (end_beam_broken) begin
                        mute_st_r <= M_LOCKED;
                    end else if (mute_end) begin
                        mute_st_r <= field_broken ? M_LOCKED : M_NORMAL;
                    end
                end
                M_RESTART, M_LOCKED: begin
                    if (reset_press_ok && !error_in) begin
                        mute_st_r <= (mute_mode && both_on) ?
                            M_MUTING : M_NORMAL;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            safety_switch_output_out <= 1'b0;
            muting_active_out        <= 1'b0;
            restart_required_out     <= 1'b0;
        end else begin
            safety_switch_output_out <= (mute_st_r == M_MUTING) ?
                !end_beam_broken :
                (mute_st_r == M_NORMAL) && !field_broken && !error_in;
            muting_active_out    <= mute_st_r == M_MUTING;
            restart_required_out <= mute_st_r == M_RESTART;
        end
    end
endmodule

// File: mbc_chk.sv
`timescale 1ns/10ps
module mbc_chk
    import mbc_pkg::*;
#(
    parameter int unsigned     BEAMS      = 8,
    parameter int unsigned     DROPOUT    = 6,
    parameter int unsigned     SINGLE_MAX = 40,
    parameter longint unsigned MUTE_MAX   = 200
) (
    input wire logic             clk_in,
    input wire logic             nrst_in,
    input wire logic [2:0]       mode_in,
    input wire logic             function_group_one_in,
    input wire logic [BEAMS-1:0] beam_blocked_in,
    input wire logic             mute_sensor_a_in,
    input wire logic             mute_sensor_b_in,
    input wire logic             error_in,
    input wire logic             safety_switch_output_out,
    input wire logic             muting_active_out,
    input wire logic             reduced_resolution_out,
    input wire logic             floating_blanking_out,
    input wire logic [7:0]       user_msg_out,
    input wire logic [3:0]       area_count_out
);
    // ------------------------------------------------
    // run lengths of sensor and muting levels, and the last three both-on samples
    // ------------------------------------------------
    logic [31:0] both_off_r;
    logic [31:0] a_off_r;
    logic [31:0] b_off_r;
    logic [31:0] mute_r;
    logic [2:0]  both_on_r;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            both_off_r <= 32'h0;
            a_off_r    <= 32'h0;
            b_off_r    <= 32'h0;
            mute_r     <= 32'h0;
            both_on_r  <= 3'h0;
        end else begin
            both_off_r <= (mute_sensor_a_in | mute_sensor_b_in) ?
                          32'h0 : both_off_r + 32'h1;
            a_off_r    <= mute_sensor_a_in ? 32'h0 : a_off_r + 32'h1;
            b_off_r    <= mute_sensor_b_in ? 32'h0 : b_off_r + 32'h1;
            mute_r     <= muting_active_out ? mute_r + 32'h1 : 32'h0;
            both_on_r  <= {both_on_r[1:0],
                           mute_sensor_a_in & mute_sensor_b_in};
        end
    end
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    a_fb_rr_tied: assert property (
        reduced_resolution_out == floating_blanking_out)
        else $error("resolution and blanking differ");
    a_rr_mode_only: assert property (
        (mode_in != MODE_THREE || !function_group_one_in)[*3]
        |-> !reduced_resolution_out)
        else $error("reduced resolution outside mode three");
    a_mute_mode_only: assert property (
        (mode_in != MODE_FOUR && mode_in != MODE_SIX)[*3]
        |-> !muting_active_out)
        else $error("muting outside modes four and six");
    a_mute_needs_both: assert property (
        $rose(muting_active_out) |-> both_on_r != 3'h0)
        else $error("muting started without both sensors");
    a_mute_keeps_on: assert property (
        $past(safety_switch_output_out) && $past(muting_active_out)
        && muting_active_out && mode_in == MODE_FOUR && !error_in
        && !$past(error_in) |-> safety_switch_output_out)
        else $error("output dropped while muting");
    a_both_off_end: assert property (
        both_off_r > DROPOUT + 4 |-> !muting_active_out)
        else $error("muting kept with both sensors off");
    a_single_off_end: assert property (
        (a_off_r > SINGLE_MAX + 4 || b_off_r > SINGLE_MAX + 4)
        |-> !muting_active_out)
        else $error("muting kept with one sensor off");
    a_mute_timeout: assert property (
        mute_r <= MUTE_MAX + 4)
        else $error("muting longer than its limit");
    a_end_beam_off: assert property (
        (mode_in == MODE_SIX && beam_blocked_in[BEAMS-1])[*3]
        |-> !safety_switch_output_out)
        else $error("end beam broken but output on");
    a_field_break_off: assert property (
        (!muting_active_out && !floating_blanking_out
         && beam_blocked_in != '0)[*3] |-> !safety_switch_output_out)
        else $error("field broken but output on");
    a_error_blocks: assert property (
        error_in[*3] |-> !safety_switch_output_out)
        else $error("output on during error");
    a_msg_codes: assert property (
        user_msg_out == MSG_NONE || user_msg_out == TEACH_SIZE_ERROR_MSG)
        else $error("unknown message code");
    a_area_limit: assert property (
        area_count_out <= NUM_AREAS)
        else $error("too many areas");
endmodule
bind muting_blanking_control mbc_chk #(
    .BEAMS(BEAMS), .DROPOUT(DROPOUT), .SINGLE_MAX(SINGLE_MAX),
    .MUTE_MAX(MUTE_MAX)
) chk_u (
    .clk_in, .nrst_in, .mode_in, .function_group_one_in,
    .beam_blocked_in, .mute_sensor_a_in, .mute_sensor_b_in, .error_in,
    .safety_switch_output_out, .muting_active_out,
    .reduced_resolution_out, .floating_blanking_out, .user_msg_out,
    .area_count_out
);

// File: mbc_partner.sv
`timescale 1ns/10ps
module mbc_partner (
    input  wire logic clk_in,
    output logic      ctrl_a_out,
    output logic      ctrl_b_out,
    output logic      teach_key_out,
    output logic      reset_button_out,
    output logic      sensor_a_out,
    output logic      sensor_b_out
);
    initial begin
        ctrl_a_out       = 1'b0;
        ctrl_b_out       = 1'b1;
        teach_key_out    = 1'b0;
        reset_button_out = 1'b0;
        sensor_a_out     = 1'b0;
        sensor_b_out     = 1'b0;
    end
    // key 0 is the teach key, key 1 the reset button
    task automatic press(input logic key, input int n);
        @(posedge clk_in);
        if (key) begin
            reset_button_out <= 1'b1;
        end else begin
            teach_key_out <= 1'b1;
        end
        repeat (n) @(posedge clk_in);
        reset_button_out <= 1'b0;
        teach_key_out    <= 1'b0;
    endtask
    task automatic sensors(input logic a, input logic b);
        @(posedge clk_in);
        sensor_a_out <= a;
        sensor_b_out <= b;
    endtask
    // second channel flips gap cycles after the first
    task automatic invert(input int gap);
        @(posedge clk_in);
        ctrl_a_out <= !ctrl_a_out;
        repeat (gap) @(posedge clk_in);
        ctrl_b_out <= !ctrl_b_out;
    endtask
endmodule

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import mbc_pkg::*;
    localparam int unsigned BEAMS = 8;
    localparam int unsigned DROP  = 6;
    localparam int unsigned SGL   = 40;
    localparam int unsigned MUTE  = 200;
    logic             clk_in  = 1'b0;
    logic             nrst_in = 1'b0;
    logic [2:0]       mode    = MODE_FOUR;
    logic             fg_one  = 1'b1;
    logic [BEAMS-1:0] beams   = 8'h00;
    logic             err     = 1'b0;
    logic             ca, cb, tk, rb, sa, sb;
    logic             safe, ind, mute, rr, fb, seen, hi, lo, hold, rreq;
    logic [7:0]       msg;
    logic [3:0]       areas;
    int               failures    = 0;
    int               comparisons = 0;
    always #50 clk_in = ~clk_in;
    mbc_partner partner_u (
        .clk_in, .ctrl_a_out(ca), .ctrl_b_out(cb), .teach_key_out(tk),
        .reset_button_out(rb), .sensor_a_out(sa), .sensor_b_out(sb));
    muting_blanking_control #(
        .BEAMS(BEAMS), .PRESS_MIN(5), .PRESS_MAX(40), .INVERT_MAX(10),
        .DROPOUT(DROP), .SINGLE_MAX(SGL), .MUTE_MAX(MUTE), .FLASH_HALF(4)
    ) dut_u (
        .clk_in, .nrst_in, .mode_in(mode), .function_group_one_in(fg_one),
        .beam_blocked_in(beams), .ctrl_a_in(ca), .ctrl_b_in(cb),
        .teach_key_in(tk), .reset_button_in(rb), .mute_sensor_a_in(sa),
        .mute_sensor_b_in(sb), .error_in(err),
        .safety_switch_output_out(safe), .blanking_indicator_out(ind),
        .muting_active_out(mute), .reduced_resolution_out(rr),
        .floating_blanking_out(fb), .restart_required_out(rreq),
        .user_msg_out(msg), .area_count_out(areas));
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    task automatic conclude();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        step(20000);
        failures++;
        conclude();
    end
    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        step(12);
        chk(8'(safe), 8'h00);
        chk(msg, MSG_NONE);
        nrst_in <= 1'b1;
        partner_u.press(1'b1, 2);
        step(4);
        chk(8'(safe), 8'h00);
        partner_u.press(1'b1, 10);
        step(4);
        chk(8'(safe), 8'h01);
        note("restart");
        partner_u.sensors(1'b1, 1'b0);
        step(10);
        chk(8'(mute), 8'h00);
        partner_u.sensors(1'b1, 1'b1);
        step(4);
        chk(8'(mute), 8'h01);
        beams <= 8'h0F;
        step(5);
        chk(8'(safe), 8'h01);
        partner_u.sensors(1'b0, 1'b1);
        step(3);
        partner_u.sensors(1'b1, 1'b1);
        step(3);
        chk(8'(mute), 8'h01);
        beams <= 8'h00;
        partner_u.sensors(1'b0, 1'b0);
        step(DROP + 6);
        chk(8'(mute), 8'h00);
        chk(8'(safe), 8'h01);
        partner_u.sensors(1'b1, 1'b1);
        step(4);
        partner_u.sensors(1'b0, 1'b1);
        step(SGL + 6);
        chk(8'(mute), 8'h00);
        partner_u.sensors(1'b1, 1'b1);
        step(4);
        chk(8'(mute), 8'h01);
        step(MUTE - 10);
        seen = 1'b0;
        repeat (30) begin
            step(1);
            seen |= !mute;
        end
        chk(8'(seen), 8'h01);
        partner_u.sensors(1'b0, 1'b0);
        step(DROP + 6);
        partner_u.sensors(1'b1, 1'b1);
        step(4);
        beams <= 8'h01;
        partner_u.sensors(1'b0, 1'b0);
        step(DROP + 6);
        chk(8'(safe), 8'h00);
        beams <= 8'h00;
        step(4);
        chk(8'(safe), 8'h00);
        partner_u.press(1'b1, 10);
        step(4);
        chk(8'(safe), 8'h01);
        err <= 1'b1;
        partner_u.press(1'b1, 10);
        step(4);
        chk(8'(safe), 8'h00);
        err <= 1'b0;
        partner_u.press(1'b1, 10);
        step(4);
        chk(8'(safe), 8'h01);
        chk(8'(rreq), 8'h00);
        partner_u.sensors(1'b1, 1'b1);
        beams <= 8'h01;
        step(4);
        chk(8'(rreq), 8'h01);
        chk(8'(safe), 8'h00);
        partner_u.press(1'b1, 10);
        step(4);
        chk(8'(rreq), 8'h00);
        chk(8'(mute), 8'h01);
        chk(8'(safe), 8'h01);
        note("muting");
        mode <= MODE_SIX;
        partner_u.sensors(1'b1, 1'b1);
        step(4);
        beams <= 8'h80;
        step(5);
        chk(8'(safe), 8'h00);
        beams <= 8'h00;
        mode  <= MODE_ONE;
        step(6);
        chk(8'(mute), 8'h00);
        partner_u.sensors(1'b0, 1'b0);
        note("partial");
        mode <= MODE_THREE;
        partner_u.press(1'b0, 10);
        {hi, lo} = 2'b00;
        repeat (12) begin
            step(1);
            hi |= (ind === 1'b1);
            lo |= (ind === 1'b0);
        end
        chk(8'(hi & lo), 8'h01);
        beams <= 8'h06;
        step(3);
        beams <= 8'h0C;
        step(3);
        beams <= 8'h00;
        partner_u.press(1'b0, 10);
        step(4);
        chk(8'(areas), 8'h01);
        partner_u.invert(0);
        step(4);
        chk(8'(fb), 8'h01);
        chk(8'(rr), 8'h01);
        chk(8'(ind), 8'h01);
        hold = safe;
        beams <= 8'h06;
        step(4);
        chk(8'(safe), 8'(hold));
        beams  <= 8'h00;
        fg_one <= 1'b0;
        step(4);
        chk(8'(rr), 8'h00);
        fg_one <= 1'b1;
        partner_u.invert(0);
        step(4);
        chk(8'(fb), 8'h00);
        partner_u.invert(15);
        step(4);
        chk(8'(fb), 8'h00);
        partner_u.press(1'b0, 10);
        step(10);
        partner_u.press(1'b0, 10);
        step(4);
        chk(8'(areas), 8'h00);
        chk(8'(ind), 8'h00);
        partner_u.press(1'b0, 10);
        beams <= 8'h01;
        step(3);
        beams <= 8'h07;
        step(5);
        chk(msg, TEACH_SIZE_ERROR_MSG);
        beams <= 8'h00;
        note("blanking");
        conclude();
    end
endmodule
